/* File: rtl/wssc_ctrl.sv */
// Supervisory state machine and safety contact drive of the cabinet side
// Operation
// - Idle without terminal keeps stop contact closed
// - Run only after coupling; contacts follow terminal
// - Safe state opens stop and enabling contacts; selector holds
// - Lost radio link after coupling enters safe
// - Any self-test or runtime failure enters emergency
// - Emergency ignores commands, keeps stop contacts open
// - Emergency is left only by reset (rst_b low)
// - Key mode is a fixed factory setting
// - Double key: pairing data only from keys
// - Double key: either key fits either side
// - Single key: couple only with written module
// - Terminal is bound to no particular key
// - Every message carries key identity; foreign rejected
// - One terminal controls one station only
// - Safe records whether it came from run or uncoupling
// - Failed coupling or uncoupling timeout enters safe
`timescale 1ns/1ns
module wssc_ctrl
    import wssc_pkg::*;
#(
    parameter int LINK_CYC = LINK_TMO_CYC,
    parameter int CPL_CYC = CPL_TMO_CYC
)
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic factory_double_key, // Factory strap pin
    input wire logic power_on_self_test_fail, // Power-on self-test failed, pin
    input wire logic rtt_fail, // Runtime test failed, pin
    input wire logic cab_key_present, // Cabinet key inserted, pin
    input wire logic [UID_W-1:0] cab_key_uid, // Cabinet key content
    input wire logic [UID_W-1:0] radio_uid, // Cabinet radio module identity
    input wire logic msg_valid, // Received message, one-cycle pulse
    input wire logic [UID_W-1:0] msg_uid, // Key identity in message
    input wire logic [TERM_W-1:0] msg_term, // Sending terminal address
    input wire logic [2:0] msg_cmd, // Message command
    input wire logic msg_stop, // Terminal stop button closed
    input wire logic msg_enable, // Terminal enabling device closed
    input wire logic [SEL_W-1:0] msg_select, // Terminal state selector
    output logic out_stop_q, // Stop contact closed
    output logic out_enable_q, // Enabling contact closed
    output logic [SEL_W-1:0] out_select_q, // State selector contacts
    output logic tx_valid_q, // Reply to accepted message, pulse
    output logic [UID_W-1:0] tx_uid_q, // Key identity stamped on reply
    output wssc_state_t state_q, // Supervisory state
    output logic safe_run_q, // Safe variant: entered from run or uncouple
    output logic double_q // Captured key mode
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and factory strap capture
    logic [SYNC_W-1:0] sy1_q, sy2_q;
    logic [1:0] cap_cnt_q, cap_cnt_d;
    logic cap_done_q, cap_done_d, double_d;

    // Strap is taken once after release; nothing later can move it
    always_comb
    begin
        cap_cnt_d = cap_cnt_q;
        cap_done_d = cap_done_q;
        double_d = double_q;
        if (!cap_done_q)
        begin
            if (cap_cnt_q == CAP_WAIT)
            begin
                cap_done_d = 1'b1;
                double_d = sy2_q[SY_STRAP];
            end
            else
            begin
                cap_cnt_d = cap_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sy1_q <= '0;
            sy2_q <= '0;
            cap_cnt_q <= '0;
            cap_done_q <= 1'b0;
            double_q <= 1'b0;
        end
        else
        begin
            sy1_q <= {factory_double_key, cab_key_present, rtt_fail, power_on_self_test_fail};
            sy2_q <= sy1_q;
            cap_cnt_q <= cap_cnt_d;
            cap_done_q <= cap_done_d;
            double_q <= double_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Message screening and supervision timers
    logic [UID_W-1:0] session_uid;
    logic [TERM_W-1:0] term_q, term_d;
    logic uid_ok, locked, acc, fail_any, link_exp, cpl_exp;

    wssc_key_match u_key (
        .double_mode(double_q),
        .key_present(sy2_q[SY_KEY]),
        .key_uid(cab_key_uid),
        .radio_uid(radio_uid),
        .msg_uid(msg_uid),
        .session_uid(session_uid),
        .uid_ok(uid_ok)
    );

    // While coupling, running or uncoupling, addresses other than the session terminal are shut out
    assign locked = (state_q == ST_COUPLE) || (state_q == ST_RUN)
                  || (state_q == ST_UNCPL);
    assign acc = msg_valid && uid_ok && (state_q != ST_OFF)
               && (state_q != ST_EMG)
               && (!locked || (msg_term == term_q));

    // Either side's test failure; terminal reports its own by message
    assign fail_any = sy2_q[SY_POWER_ON_SELF_TEST] || sy2_q[SY_RTT]
                    || (msg_valid && uid_ok && (msg_cmd == CMD_FAIL));

    // Link silence counts while the terminal is meant to be talking
    wssc_timer #(
        .CYCLES(LINK_CYC)
    ) u_link_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run((state_q == ST_RUN) || (state_q == ST_UNCPL)),
        .restart(acc),
        .expired(link_exp)
    );

    // One window covers both coupling and uncoupling procedures
    wssc_timer #(
        .CYCLES(CPL_CYC)
    ) u_cpl_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .run((state_q == ST_COUPLE) || (state_q == ST_UNCPL)),
        .restart(1'b0),
        .expired(cpl_exp)
    );

    ////////////////////////////////////////////////////////////////////
    // Supervisory state machine
    wssc_state_t state_d;
    logic safe_run_d;

    // Failure outranks every other event, including a pending command
    always_comb
    begin
        state_d = state_q;
        safe_run_d = safe_run_q;
        term_d = term_q;
        if (fail_any || (state_q == ST_EMG))
            state_d = ST_EMG;
        else
        begin
            case (state_q)
                ST_OFF:
                    if (cap_done_q)
                        state_d = ST_IDLE;
                ST_IDLE:
                    if (acc && (msg_cmd == CMD_COUPLE))
                    begin
                        state_d = ST_COUPLE;
                        term_d = msg_term;
                    end
                ST_COUPLE:
                    if (acc && (msg_cmd == CMD_CONFIRM))
                        state_d = ST_RUN;
                    else if (cpl_exp)
                    begin
                        state_d = ST_SAFE;
                        safe_run_d = 1'b0;
                    end
                ST_RUN:
                    if (link_exp)
                    begin
                        state_d = ST_SAFE;
                        safe_run_d = 1'b1;
                    end
                    else if (acc && (msg_cmd == CMD_UNCOUPLE))
                        state_d = ST_UNCPL;
                ST_UNCPL:
                    if (acc && (msg_cmd == CMD_CONFIRM))
                        state_d = ST_IDLE;
                    else if (cpl_exp || link_exp)
                    begin
                        state_d = ST_SAFE;
                        safe_run_d = 1'b1;
                    end
                ST_SAFE:
                    // Data from the same terminal resumes run directly when safe came from run or uncoupling
                    if (acc && (msg_cmd == CMD_COUPLE))
                    begin
                        state_d = ST_COUPLE;
                        term_d = msg_term;
                    end
                    else if (acc && safe_run_q && (msg_cmd == CMD_DATA)
                             && (msg_term == term_q))
                        state_d = ST_RUN;
                default:
                    state_d = ST_SAFE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_OFF;
            safe_run_q <= 1'b0;
            term_q <= TERM_RST;
        end
        else
        begin
            state_q <= state_d;
            safe_run_q <= safe_run_d;
            term_q <= term_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Safety contacts and replies

    logic stop_d, enable_d, tx_valid_d, run_upd;
    logic [SEL_W-1:0] select_d;
    logic [UID_W-1:0] tx_uid_d;

    assign run_upd = acc && ((msg_cmd == CMD_DATA) || (msg_cmd == CMD_CONFIRM));

    // Decoded from next state so contacts move on the deciding edge
    always_comb
    begin
        stop_d = 1'b0;
        enable_d = 1'b0;
        select_d = out_select_q; // Selector keeps its last valid value
        case (state_d)
            ST_IDLE:
            begin
                stop_d = 1'b1;
            end
            ST_RUN:
            begin
                stop_d = out_stop_q;
                enable_d = out_enable_q;
                if (run_upd)
                begin
                    stop_d = msg_stop;
                    enable_d = msg_enable;
                    select_d = msg_select;
                end
            end
            default:
            begin
                stop_d = 1'b0;
            end
        endcase
        tx_valid_d = acc;
        tx_uid_d = acc ? session_uid : tx_uid_q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_stop_q <= 1'b0;
            out_enable_q <= 1'b0;
            out_select_q <= SEL_RST;
            tx_valid_q <= 1'b0;
            tx_uid_q <= UID_RST;
        end
        else
        begin
            out_stop_q <= stop_d;
            out_enable_q <= enable_d;
            out_select_q <= select_d;
            tx_valid_q <= tx_valid_d;
            tx_uid_q <= tx_uid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_run_data;
        state_q == ST_RUN && acc && msg_cmd == CMD_DATA && !fail_any && !link_exp;
    endsequence
    sequence s_run_exit;
        state_q == ST_RUN ##1 state_q != ST_RUN;
    endsequence

    idle_stop_closed_a: assert property (state_q == ST_IDLE |-> out_stop_q)
        else $error("idle without closed stop contact");
    run_follows_a: assert property (s_run_data |=> out_stop_q == $past(msg_stop)
        && out_enable_q == $past(msg_enable) && out_select_q == $past(msg_select))
        else $error("run contacts do not follow terminal");
    safe_open_a: assert property (state_q == ST_SAFE |-> !out_stop_q && !out_enable_q)
        else $error("contact closed in safe");
    link_loss_a: assert property (state_q == ST_RUN && link_exp && !fail_any
        |=> state_q == ST_SAFE && safe_run_q)
        else $error("link loss did not enter safe");
    fail_emg_a: assert property (fail_any |=> state_q == ST_EMG)
        else $error("test failure did not enter emergency");
    emg_open_a: assert property (state_q == ST_EMG |-> !out_stop_q && !tx_valid_d)
        else $error("emergency not open or answering");
    emg_hold_a: assert property (state_q == ST_EMG |=> state_q == ST_EMG [*8])
        else $error("emergency was left");
    mode_fixed_a: assert property (cap_done_q |=> $stable(double_q))
        else $error("key mode changed");
    foreign_drop_a: assert property (msg_valid && !uid_ok |=> !tx_valid_q)
        else $error("foreign message answered");
    other_term_a: assert property (locked && msg_valid && msg_term != term_q
        |=> !tx_valid_q && $stable(term_q))
        else $error("second terminal accepted");
    cpl_timeout_a: assert property (state_q == ST_COUPLE && cpl_exp && !fail_any
        && !(acc && msg_cmd == CMD_CONFIRM) |=> state_q == ST_SAFE && !safe_run_q)
        else $error("coupling timeout not handled");
    run_exit_a: assert property (s_run_exit |-> !out_enable_q)
        else $error("enabling contact closed after run");

endmodule

/* File: common/wssc_pkg.sv */
// Shared constants and types for the wireless safety state controller
package wssc_pkg;

    // Clock period and supervision times
    localparam int CLK_NS = 8;
    localparam int LINK_TMO_US = 100; // Silence allowed on a live link
    localparam int CPL_TMO_MS = 5; // Coupling or uncoupling window
    // Longest times, so rounded down to whole cycles
    localparam int LINK_TMO_CYC = (LINK_TMO_US * 1000) / CLK_NS;
    localparam int CPL_TMO_CYC = (CPL_TMO_MS * 1000000) / CLK_NS;

    // Field widths
    localparam int UID_W = 32;
    localparam int TERM_W = 16;
    localparam int SEL_W = 2;

    // Synchroniser bit positions for the pin inputs
    localparam int SYNC_W = 4;
    localparam int SY_POWER_ON_SELF_TEST = 0;
    localparam int SY_RTT = 1;
    localparam int SY_KEY = 2;
    localparam int SY_STRAP = 3;

    // Edges after reset release before the strap is taken
    localparam logic [1:0] CAP_WAIT = 2'h2;

    // Values after reset
    localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
    localparam logic [UID_W-1:0] UID_RST = 32'h0;
    localparam logic [TERM_W-1:0] TERM_RST = 16'h0;

    // Supervisory states, Gray coded along off-idle-couple-run-uncouple-safe
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_IDLE = 3'h1,
        ST_COUPLE = 3'h3,
        ST_RUN = 3'h2,
        ST_UNCPL = 3'h6,
        ST_SAFE = 3'h7,
        ST_EMG = 3'h4
    } wssc_state_t;

    // Message commands from the terminal
    typedef enum logic [2:0] {
        CMD_DATA = 3'h0,
        CMD_COUPLE = 3'h1,
        CMD_CONFIRM = 3'h2,
        CMD_UNCOUPLE = 3'h3,
        CMD_FAIL = 3'h4
    } wssc_cmd_t;

endpackage

/* File: rtl/wssc_timer.sv */
// Saturating supervision timer for link and coupling windows
`timescale 1ns/1ns
module wssc_timer
    import wssc_pkg::*;
#(
    parameter int CYCLES = 16
)
(
    input wire logic clk, // System clock
    input wire logic rst_b, // Async reset, active low
    input wire logic run, // Count while high, clear while low
    input wire logic restart, // Start the window again
    output logic expired // Window used up, level
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // Saturate so a late restart never wraps into a false expiry
    always_comb
    begin
        cnt_d = cnt_q;
        if (!run || restart)
        begin
            cnt_d = '0;
        end
        else if (cnt_q != LAST)
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = (cnt_q == LAST);

endmodule

/* File: rtl/wssc_key_match.sv */
// Pairing key check: picks the session identity and screens messages
`timescale 1ns/1ns
module wssc_key_match
    import wssc_pkg::*;
(
    input wire logic double_mode, // Factory mode, high for double key
    input wire logic key_present, // Cabinet key inserted
    input wire logic [UID_W-1:0] key_uid, // Identity read from cabinet key
    input wire logic [UID_W-1:0] radio_uid, // Identity of cabinet radio module
    input wire logic [UID_W-1:0] msg_uid, // Identity carried by message
    output logic [UID_W-1:0] session_uid, // Identity to stamp on replies
    output logic uid_ok // Message belongs to this pairing
);

    // Terminal identity never enters the check, so any terminal may pair
    always_comb
    begin
        if (double_mode)
        begin
            // No stored pairing data; either identical key fits here
            session_uid = key_uid;
            uid_ok = key_present && (msg_uid == key_uid);
        end
        else
        begin
            // Terminal key was written with this radio module identity
            session_uid = radio_uid;
            uid_ok = (msg_uid == radio_uid);
        end
    end

endmodule

/* File: verification/wssc_term_model.sv */
// Terminal-side partner model that feeds received messages to the controller
`timescale 1ns/1ns
module wssc_term_model
    import wssc_pkg::*;
(
    input wire logic clk, // System clock
    output logic msg_valid, // Message strobe
    output logic [UID_W-1:0] msg_uid, // Key identity
    output logic [TERM_W-1:0] msg_term, // Terminal address
    output logic [2:0] msg_cmd, // Command
    output logic msg_stop, // Stop button closed
    output logic msg_enable, // Enabling device closed
    output logic [SEL_W-1:0] msg_select // Selector position
);
    typedef struct packed {
        logic [3:0] lag;
        logic [UID_W-1:0] unique_system_identifier;
        logic [TERM_W-1:0] term;
        logic [2:0] cmd;
        logic [3:0] ctl;
    } wssc_msg_t;
    wssc_msg_t pend[$];
    wssc_msg_t out_q = '0;
    logic vld_q = 1'b0;
    int idle_n = 0;

    ////////////////////////////////////////////////////////////////////////
    // Queue one message; lag idles the link first, as a slow terminal does
    task automatic put(input logic [UID_W-1:0] unique_system_identifier, input logic [TERM_W-1:0] term,
            input logic [2:0] cmd, input logic [3:0] ctl, input logic [3:0] lag);
        pend.push_back({lag, unique_system_identifier, term, cmd, ctl}); // Key identity in each message
    endtask

    // Fields invert every idle cycle so stale data never passes for a message
    always @(posedge clk)
    begin
        if (pend.size() > 0 && idle_n >= pend[0].lag)
        begin
            out_q <= pend.pop_front();
            idle_n = 0;
            vld_q <= 1'b1;
        end
        else
        begin
            out_q <= ~out_q;
            idle_n = idle_n + int'(pend.size() > 0);
            vld_q <= 1'b0;
        end
    end

    // Outputs straight from the held message
    assign msg_valid = vld_q;
    assign msg_uid = out_q.unique_system_identifier;
    assign msg_term = out_q.term;
    assign msg_cmd = out_q.cmd;
    assign msg_stop = out_q.ctl[3];
    assign msg_enable = out_q.ctl[2];
    assign msg_select = out_q.ctl[1:0];
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the cabinet supervisory controller
`timescale 1ns/1ns
module tb_top
    import wssc_pkg::*;
;
    localparam int LINK_N = 20;
    localparam int CPL_N = 40;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b0;
    logic power_on_self_test_f = 1'b0;
    logic rtt_f = 1'b0;
    logic key_in = 1'b0;
    logic [31:0] key_uid = 32'h0;
    logic [31:0] rad_uid = 32'h0;
    logic [31:0] seed_q = 32'h564dd5be;
    logic [31:0] r;
    logic [15:0] ta, tb2, tc;
    logic [3:0] ctl;
    logic [3:0] ctls [8];
    int fail_count = 0;
    int samples_checked = 0;
    int cyc_n = 0;
    logic msg_valid, msg_stop, msg_enable, out_stop_q, out_enable_q;
    logic tx_valid_q, safe_run_q, double_q;
    logic [UID_W-1:0] msg_uid, tx_uid_q;
    logic [TERM_W-1:0] msg_term;
    logic [2:0] msg_cmd;
    logic [SEL_W-1:0] msg_select, out_select_q;
    wssc_state_t state_q;

    ////////////////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    always #4 clk = ~clk;

    // Short timer values keep the supervision scenarios brief
    wssc_ctrl #(.LINK_CYC(LINK_N), .CPL_CYC(CPL_N)) dut_u (
        .clk(clk), .rst_b(rst_b), .factory_double_key(strap), .power_on_self_test_fail(power_on_self_test_f),
        .rtt_fail(rtt_f), .cab_key_present(key_in), .cab_key_uid(key_uid),
        .radio_uid(rad_uid), .msg_valid(msg_valid), .msg_uid(msg_uid),
        .msg_term(msg_term), .msg_cmd(msg_cmd), .msg_stop(msg_stop),
        .msg_enable(msg_enable), .msg_select(msg_select), .out_stop_q(out_stop_q),
        .out_enable_q(out_enable_q), .out_select_q(out_select_q),
        .tx_valid_q(tx_valid_q), .tx_uid_q(tx_uid_q), .state_q(state_q),
        .safe_run_q(safe_run_q), .double_q(double_q));

    // Far side of the radio link
    wssc_term_model term_u (
        .clk(clk), .msg_valid(msg_valid), .msg_uid(msg_uid), .msg_term(msg_term),
        .msg_cmd(msg_cmd), .msg_stop(msg_stop), .msg_enable(msg_enable),
        .msg_select(msg_select));

    ////////////////////////////////////////////////////////////////////////
    // Repeatable random source
    function automatic logic [31:0] rnd();
        seed_q = {seed_q[30:0], seed_q[31] ^ seed_q[21] ^ seed_q[1] ^ seed_q[0]};
        return seed_q;
    endfunction

    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Settle one nanosecond past the edge before sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic st(input wssc_state_t s, input logic stp, input logic en);
        chk({29'h0, state_q}, {29'h0, s});
        chk({30'h0, out_stop_q, out_enable_q}, {30'h0, stp, en});
    endtask

    task automatic run_chk(input logic [3:0] c);
        st(ST_RUN, c[3], c[2]);
        chk({30'h0, out_select_q}, {30'h0, c[1:0]});
    endtask

    // One message, then the reply is checked two edges (plus lag) later
    task automatic send(input logic [31:0] unique_system_identifier, input logic [15:0] term,
            input logic [2:0] cmd, input logic [3:0] c, input logic ok, input int lag);
        term_u.put(unique_system_identifier, term, cmd, c, lag[3:0]);
        tick(2 + lag);
        chk({31'h0, tx_valid_q}, {31'h0, ok});
        if (ok)
            chk(tx_uid_q, unique_system_identifier);
    endtask

    task automatic do_reset(input logic dbl, input logic pf);
        int n;
        n = 0;
        @(posedge clk);
        rst_b <= 1'b0;
        strap <= dbl;
        power_on_self_test_f <= pf;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        while (state_q === ST_OFF && n < 12)
        begin
            tick(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard: far above the under two hundred cycles the scenarios need
    always @(posedge clk)
    begin
        cyc_n++;
        if (cyc_n == 3000)
        begin
            fail_count++;
            end_sim();
        end
    end

    // Main sequence: single-key pass, then double-key and failure cases
    initial
    begin
        rad_uid <= rnd();
        key_uid <= ~rnd();
        r = rnd();
        ta = r[15:0];
        tb2 = ~ta;
        tc = r[31:16] ^ 16'h5a5a;
        do_reset(1'b0, 1'b0);
        st(ST_IDLE, 1'b1, 1'b0);
        @(posedge clk);
        strap <= 1'b1;
        tick(6);
        chk({31'h0, double_q}, 32'h0); // Strap moved after capture
        send(~rad_uid, ta, CMD_COUPLE, 4'h0, 1'b0, 0);
        send(rad_uid, ta, CMD_COUPLE, 4'h0, 1'b1, 0);
        st(ST_COUPLE, 1'b0, 1'b0);
        send(rad_uid, tb2, CMD_CONFIRM, 4'hf, 1'b0, 0);
        r = rnd();
        send(rad_uid, ta, CMD_CONFIRM, r[3:0], 1'b1, 3);
        run_chk(r[3:0]);
        // Back-to-back data, contacts follow each message
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            ctls[i] = r[3:0];
            term_u.put(rad_uid, ta, CMD_DATA, ctls[i], 4'h0);
        end
        tick(2);
        for (int i = 0; i < 8; i++)
        begin
            run_chk(ctls[i]);
            chk({31'h0, tx_valid_q}, 32'h1);
            tick(1);
        end
        ctl = ctls[7];
        send(rad_uid, tb2, CMD_DATA, ~ctl, 1'b0, 0);
        run_chk(ctl);
        // Silence on the link
        tick(LINK_N + 4);
        st(ST_SAFE, 1'b0, 1'b0);
        chk({31'h0, safe_run_q}, 32'h1);
        chk({30'h0, out_select_q}, {30'h0, ctl[1:0]});
        send(rad_uid, ta, CMD_DATA, 4'hd, 1'b1, 0);
        run_chk(4'hd);
        send(rad_uid, ta, CMD_UNCOUPLE, 4'h0, 1'b1, 0);
        st(ST_UNCPL, 1'b0, 1'b0);
        send(rad_uid, ta, CMD_CONFIRM, 4'h0, 1'b1, 0);
        st(ST_IDLE, 1'b1, 1'b0);
        // Coupling left unfinished
        send(rad_uid, ta, CMD_COUPLE, 4'h0, 1'b1, 0);
        tick(CPL_N + 4);
        st(ST_SAFE, 1'b0, 1'b0);
        chk({31'h0, safe_run_q}, 32'h0);
        send(rad_uid, tc, CMD_COUPLE, 4'h0, 1'b1, 0);
        send(rad_uid, tc, CMD_CONFIRM, 4'hb, 1'b1, 0);
        run_chk(4'hb);
        // Runtime failure, then commands and a cleared pin are ignored
        @(posedge clk);
        rtt_f <= 1'b1;
        tick(6);
        st(ST_EMG, 1'b0, 1'b0);
        @(posedge clk);
        rtt_f <= 1'b0;
        send(rad_uid, tc, CMD_COUPLE, 4'h0, 1'b0, 0);
        send(rad_uid, tc, CMD_DATA, 4'hf, 1'b0, 0);
        tick(10);
        st(ST_EMG, 1'b0, 1'b0);
        // Double-key mode with key inserted
        @(posedge clk);
        key_in <= 1'b1;
        do_reset(1'b1, 1'b0);
        chk({31'h0, double_q}, 32'h1);
        send(rad_uid, ta, CMD_COUPLE, 4'h0, 1'b0, 0);
        send(key_uid, ta, CMD_COUPLE, 4'h0, 1'b1, 0);
        st(ST_COUPLE, 1'b0, 1'b0);
        term_u.put(key_uid, tb2, CMD_FAIL, 4'h0, 4'h0);
        tick(3);
        st(ST_EMG, 1'b0, 1'b0); // Terminal self-test failure
        // Double-key mode without key
        @(posedge clk);
        key_in <= 1'b0;
        do_reset(1'b1, 1'b0);
        send(key_uid, ta, CMD_COUPLE, 4'h0, 1'b0, 0);
        st(ST_IDLE, 1'b1, 1'b0);
        // Power-on self-test failing from the start
        do_reset(1'b0, 1'b1);
        tick(2);
        st(ST_EMG, 1'b0, 1'b0);
        end_sim();
    end
endmodule
